// *** core/sensor_feature_config_regs.sv ***
/*
  Feature configuration register bank of the motion sensor: interface
  selection, detector rearm and FIFO freeze, burst address walking, and a
  small stream FIFO of samples with a two-entry output buffer.
  Assumes the serial front end presents one-cycle register strobes on
  core_clk_in and that sensor, detector and mode inputs are synchronous.
*/
// Behaviour
// - No select bits: keep interface, block output samples
// - Two-wire select ignores serial peripheral traffic
// - Serial peripheral select ignores two-wire traffic
// - Three-wire select bit picks shared data pin
// - Freeze clear: FIFO keeps capturing on wake
// - Freeze set: FIFO stops capturing on wake
// - Detector halts after raising wake event
// - Rearm clear: only mode exit rearms detector
// - Rearm set: clearing flag rearms detector
// - Short wrap: after 0x07 return to 0x02
// - Long wrap: through 0x09 then 0x02
// - Burst settings apply on every interface
// - Without FIFO burst, burst ends at first wrap: six bytes short, eight long
// - FIFO burst: up to 32 samples in one
// - Detect-and-wake mode runs detector, pipeline, FIFO
// - Wake flag set only on detection in mode
// - Serial clears by write; two-wire by read default
`timescale 1ns/10ps
module sensor_feature_config_regs #(
  parameter int SAMPLE_WIDTH = 48,
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Register port from the serial front end
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_via_serial_in,
  output logic [7:0] reg_rdata_out,
  // Burst walking
  input wire logic burst_start_in,
  input wire logic [7:0] burst_addr_in,
  input wire logic burst_advance_in,
  output logic [7:0] burst_addr_out,
  output logic burst_end_out,
  // Interface steering
  output logic serial_port_enable_out,
  output logic two_wire_port_enable_out,
  output logic three_wire_serial_select_out,
  // Mode, detector and samples
  input wire logic [2:0] op_mode_in,
  input wire logic detector_hit_in,
  input wire logic sample_valid_in,
  input wire logic [SAMPLE_WIDTH-1:0] sample_data_in,
  input wire logic fifo_enable_in,
  output logic detect_and_wake_mode_out,
  output logic detect_wake_event_flag_out,
  output logic detector_armed_out,
  output logic axis_output_enable_out,
  output logic fifo_frozen_out,
  // Sample stream toward the output registers
  output logic sample_valid_out,
  output logic [SAMPLE_WIDTH-1:0] sample_data_out,
  input wire logic sample_ready_in,
  output logic [5:0] fifo_level_out
);
  // ****************************************
  // Configuration registers
  // ****************************************
  logic [7:0] iface_sniff_cfg; // First feature register
  logic [7:0] fifo_burst_cfg; // Second feature register
  logic pending_clear; // Flag clear strobe

  // Access to a given register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Register writes; first register low bits forced to zero
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      iface_sniff_cfg <= feature_cfg_pkg::RESET_IFACE_SNIFF_CFG;
      fifo_burst_cfg <= feature_cfg_pkg::RESET_FIFO_BURST_CFG;
    end else if (reg_write_in) begin
      if (hit(reg_addr_in, feature_cfg_pkg::ADDR_IFACE_SNIFF_CFG)) begin
        iface_sniff_cfg <= reg_wdata_in & feature_cfg_pkg::MASK_IFACE_SNIFF_WRITABLE;
      end
      if (hit(reg_addr_in, feature_cfg_pkg::ADDR_FIFO_BURST_CFG)) begin
        fifo_burst_cfg <= reg_wdata_in;
      end
    end
  end

  // Read mux; status read shows the wake flag in bit 7
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      if (hit(reg_addr_in, feature_cfg_pkg::ADDR_IFACE_SNIFF_CFG)) begin
        reg_rdata_out <= iface_sniff_cfg;
      end else if (hit(reg_addr_in, feature_cfg_pkg::ADDR_FIFO_BURST_CFG)) begin
        reg_rdata_out <= fifo_burst_cfg;
      end else if (hit(reg_addr_in, feature_cfg_pkg::ADDR_INT_STATUS)) begin
        reg_rdata_out <= {detect_wake_event_flag_out, 7'h00};
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end
  end

  // ****************************************
  // Interface steering
  // ****************************************
  logic serial_sel; // Serial peripheral chosen
  logic two_wire_sel; // Two-wire chosen
  assign serial_sel = iface_sniff_cfg[feature_cfg_pkg::BIT_SERIAL_SELECT];
  assign two_wire_sel = iface_sniff_cfg[feature_cfg_pkg::BIT_TWO_WIRE_SELECT];
  // Both zero keeps both ports as at power-up
  assign serial_port_enable_out = !two_wire_sel;
  assign two_wire_port_enable_out = !serial_sel;
  assign three_wire_serial_select_out = iface_sniff_cfg[feature_cfg_pkg::BIT_THREE_WIRE_SERIAL_SELECT];
  assign axis_output_enable_out = serial_sel | two_wire_sel;

  // Clearing method: serial writes; two-wire reads unless write-clear and two-wire select are both set
  always_comb begin
    if (!hit(reg_addr_in, feature_cfg_pkg::ADDR_INT_STATUS)) begin
      pending_clear = 1'b0;
    end else if (reg_via_serial_in) begin
      pending_clear = reg_write_in;
    end else if (fifo_burst_cfg[feature_cfg_pkg::BIT_WRITE_CLEAR_TWO_WIRE] && two_wire_sel) begin
      pending_clear = reg_write_in;
    end else begin
      pending_clear = reg_read_in;
    end
  end

  // ****************************************
  // Detector and wake flag
  // ****************************************
  logic in_wake_mode; // Detect-and-wake mode active
  logic in_wake_mode_d; // Previous cycle mode
  logic wake_set; // Detection this cycle
  assign in_wake_mode = (op_mode_in == feature_cfg_pkg::MODE_DETECT_AND_WAKE);
  assign detect_and_wake_mode_out = in_wake_mode;
  assign wake_set = in_wake_mode && detector_armed_out && detector_hit_in;

  // Mode history for exit detection
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_wake_mode_d <= 1'b0;
    end else begin
      in_wake_mode_d <= in_wake_mode;
    end
  end

  // Wake flag; a new detection wins over a clear
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      detect_wake_event_flag_out <= 1'b0;
    end else if (wake_set) begin
      detect_wake_event_flag_out <= 1'b1;
    end else if (pending_clear) begin
      detect_wake_event_flag_out <= 1'b0;
    end
  end

  // Detector arming
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      detector_armed_out <= 1'b1;
    end else if (wake_set) begin
      detector_armed_out <= 1'b0;
    end else if (in_wake_mode_d && !in_wake_mode) begin
      detector_armed_out <= 1'b1;
    end else if (pending_clear && iface_sniff_cfg[feature_cfg_pkg::BIT_DETECTOR_REARM_ON_CLEAR]) begin
      detector_armed_out <= 1'b1;
    end
  end

  // Freeze latch follows the flag when freeze is chosen
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fifo_frozen_out <= 1'b0;
    end else if (wake_set && iface_sniff_cfg[feature_cfg_pkg::BIT_FREEZE_ON_WAKE]) begin
      fifo_frozen_out <= 1'b1;
    end else if (pending_clear || !iface_sniff_cfg[feature_cfg_pkg::BIT_FREEZE_ON_WAKE]) begin
      fifo_frozen_out <= 1'b0;
    end
  end

  // ****************************************
  // Burst address walker
  // ****************************************
  feature_cfg_pkg::burst_state_t burst_state; // Walker state
  logic [7:0] wrap_addr; // Last address before wrap
  logic [5:0] sample_count; // Samples finished in burst
  logic at_wrap; // Current address is wrap point
  assign wrap_addr = fifo_burst_cfg[feature_cfg_pkg::BIT_BURST_WRAP_SELECT] ?
    feature_cfg_pkg::ADDR_BURST_WRAP_LONG : feature_cfg_pkg::ADDR_BURST_WRAP_SHORT;
  assign at_wrap = (burst_addr_out == wrap_addr);
  assign burst_end_out = (burst_state == feature_cfg_pkg::BURST_DONE);

  // Address counter and sample counting
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      burst_state <= feature_cfg_pkg::BURST_IDLE;
      burst_addr_out <= 8'h00;
      sample_count <= 6'h00;
    end else if (burst_start_in) begin
      burst_state <= feature_cfg_pkg::BURST_RUN;
      burst_addr_out <= burst_addr_in;
      sample_count <= 6'h00;
    end else begin
      unique case (burst_state)
        feature_cfg_pkg::BURST_IDLE: begin
          burst_state <= feature_cfg_pkg::BURST_IDLE;
        end
        feature_cfg_pkg::BURST_RUN: begin
          if (burst_advance_in) begin
            if (at_wrap) begin
              burst_addr_out <= feature_cfg_pkg::ADDR_BURST_FIRST;
              sample_count <= sample_count + 6'h01;
              // One sample (one wrap) unless FIFO burst; then up to the FIFO depth
              if (!fifo_burst_cfg[feature_cfg_pkg::BIT_FIFO_BURST] ||
                  sample_count == 6'(feature_cfg_pkg::FIFO_SAMPLES - 1)) begin
                burst_state <= feature_cfg_pkg::BURST_DONE;
              end
            end else begin
              burst_addr_out <= burst_addr_out + 8'h01;
            end
          end
        end
        feature_cfg_pkg::BURST_DONE: begin
          burst_state <= feature_cfg_pkg::BURST_DONE;
        end
        default: begin
          burst_state <= feature_cfg_pkg::BURST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Sample FIFO with stream mode
  // ****************************************
  localparam int PTR_W = $clog2(FIFO_DEPTH);
  logic [SAMPLE_WIDTH-1:0] fifo_mem [FIFO_DEPTH]; // Sample storage
  logic [PTR_W-1:0] wr_ptr; // Write index
  logic [PTR_W-1:0] rd_ptr; // Read index
  logic [5:0] count; // Stored samples
  logic fifo_full; // Storage full
  logic capture; // Sample accepted this cycle
  logic drop_oldest; // Stream overwrite this cycle
  logic pop; // Head moved to output buffer
  logic buf_ready; // Output buffer has room
  assign fifo_full = (count == 6'(FIFO_DEPTH));
  assign capture = sample_valid_in && fifo_enable_in && axis_output_enable_out && !fifo_frozen_out &&
    (!fifo_full || fifo_burst_cfg[feature_cfg_pkg::BIT_STREAM_MODE]);
  assign drop_oldest = capture && fifo_full && !pop;
  assign pop = (count != 6'h00) && buf_ready;
  assign fifo_level_out = count;

  // Storage write
  always_ff @(posedge core_clk_in) begin
    if (capture) begin
      fifo_mem[wr_ptr] <= sample_data_in;
    end
  end

  // Pointers and count
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= 6'h00;
    end else begin
      if (capture) begin
        wr_ptr <= wr_ptr + PTR_W'(1);
      end
      if (pop || drop_oldest) begin
        rd_ptr <= rd_ptr + PTR_W'(1);
      end
      if (capture && !pop && !drop_oldest) begin
        count <= count + 6'h01;
      end else if (pop && !capture) begin
        count <= count - 6'h01;
      end
    end
  end

  // ****************************************
  // Two-entry output buffer
  // ****************************************
  logic [SAMPLE_WIDTH-1:0] buf_data [2]; // Buffer entries
  logic buf_head; // Oldest entry index
  logic [1:0] buf_count; // Entries held
  logic buf_pop; // Receiver took a word
  assign buf_ready = (buf_count != 2'h2);
  assign buf_pop = sample_valid_out && sample_ready_in;
  assign sample_valid_out = (buf_count != 2'h0);
  assign sample_data_out = buf_data[buf_head];

  // Buffer fill and drain
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      buf_data[0] <= '0;
      buf_data[1] <= '0;
      buf_head <= 1'b0;
      buf_count <= 2'h0;
    end else begin
      if (pop) begin
        buf_data[buf_head ^ buf_count[0]] <= fifo_mem[rd_ptr];
      end
      if (buf_pop) begin
        buf_head <= !buf_head;
      end
      buf_count <= buf_count + {1'b0, pop} - {1'b0, buf_pop};
    end
  end
endmodule

// *** shared/feature_cfg_pkg.sv ***
/*
  Package for the feature configuration register bank: offsets, field
  positions, reset values, mode codes and burst address limits.
  Assumes a byte-wide register port driven by the serial interface logic.
*/
package feature_cfg_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_IFACE_SNIFF_CFG = 8'h0D;
  localparam logic [7:0] ADDR_FIFO_BURST_CFG = 8'h0E;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h09;
  localparam logic [7:0] ADDR_BURST_FIRST = 8'h02;
  localparam logic [7:0] ADDR_BURST_WRAP_SHORT = 8'h07;
  localparam logic [7:0] ADDR_BURST_WRAP_LONG = 8'h09;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RESET_IFACE_SNIFF_CFG = 8'h00;
  localparam logic [7:0] RESET_FIFO_BURST_CFG = 8'h00;
  // ****************************************
  // First register fields
  // ****************************************
  localparam int BIT_SERIAL_SELECT = 7;
  localparam int BIT_TWO_WIRE_SELECT = 6;
  localparam int BIT_THREE_WIRE_SERIAL_SELECT = 5;
  localparam int BIT_DETECTOR_REARM_ON_CLEAR = 4;
  localparam int BIT_FREEZE_ON_WAKE = 3;
  localparam logic [7:0] MASK_IFACE_SNIFF_WRITABLE = 8'hF8;
  // ****************************************
  // Second register fields
  // ****************************************
  localparam int BIT_STREAM_MODE = 5;
  localparam int BIT_WRITE_CLEAR_TWO_WIRE = 4;
  localparam int BIT_FIFO_BURST = 1;
  localparam int BIT_BURST_WRAP_SELECT = 0;
  // ****************************************
  // Operating mode codes
  // ****************************************
  localparam logic [2:0] MODE_DETECT_AND_WAKE = 3'h6;
  // ****************************************
  // Burst sizing
  // ****************************************
  localparam int SAMPLE_BYTES = 6;
  localparam int FIFO_SAMPLES = 32;
  // Burst reader state
  typedef enum logic [1:0] {
    BURST_IDLE = 2'b00,
    BURST_RUN = 2'b01,
    BURST_DONE = 2'b10
  } burst_state_t;
endpackage

// *** tb/sensor_feature_config_regs_asserts.sv ***
/*
  Port checker for the feature register bank.
  Assumes a bind to sensor_feature_config_regs, one clock domain.
*/
`timescale 1ns/10ps
module sensor_feature_config_regs_asserts (
  // Clock, reset and register port
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_via_serial_in,
  // Burst walking
  input wire logic burst_start_in,
  input wire logic [7:0] burst_addr_in,
  input wire logic burst_advance_in,
  input wire logic [7:0] burst_addr_out,
  input wire logic burst_end_out,
  // Steering, detector and FIFO
  input wire logic serial_port_enable_out,
  input wire logic two_wire_port_enable_out,
  input wire logic three_wire_serial_select_out,
  input wire logic detector_hit_in,
  input wire logic detect_and_wake_mode_out,
  input wire logic detect_wake_event_flag_out,
  input wire logic detector_armed_out,
  input wire logic axis_output_enable_out,
  input wire logic fifo_frozen_out,
  input wire logic [5:0] fifo_level_out
);
  // ****************************************
  // Shadow of written configuration
  // ****************************************
  logic [7:0] cfg1; // First register shadow
  logic [7:0] cfg2; // Second register shadow
  // Track writes to both registers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg1 <= 8'h00;
      cfg2 <= 8'h00;
    end else if (reg_write_in && reg_addr_in == 8'h0D) begin
      cfg1 <= reg_wdata_in & 8'hF8;
    end else if (reg_write_in && reg_addr_in == 8'h0E) begin
      cfg2 <= reg_wdata_in;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence clr_write;
    reg_write_in && reg_addr_in == 8'h09 && reg_via_serial_in && !detector_hit_in;
  endsequence
  sequence short_start;
    burst_start_in && burst_addr_in == 8'h02 && cfg2[1:0] == 2'h0;
  endsequence
  sequence six_steps;
    burst_advance_in [*6];
  endsequence
  a_two_wire_blocks: assert property (serial_port_enable_out == !cfg1[6])
    else $error("serial port enable wrong");
  a_serial_blocks: assert property (two_wire_port_enable_out == !cfg1[7])
    else $error("two wire port enable wrong");
  a_three_wire: assert property (three_wire_serial_select_out == cfg1[5])
    else $error("three wire select wrong");
  a_axes_gated: assert property (!axis_output_enable_out |=> fifo_level_out <= $past(fifo_level_out))
    else $error("samples stored with no interface selected");
  a_wake_cause: assert property ($rose(detect_wake_event_flag_out) |->
    $past(detect_and_wake_mode_out && detector_hit_in && detector_armed_out))
    else $error("wake flag without armed detection in mode");
  a_halt_after_wake: assert property ($rose(detect_wake_event_flag_out) |->
    !detector_armed_out && fifo_frozen_out == cfg1[3])
    else $error("detector or freeze wrong after wake");
  a_frozen_holds: assert property (fifo_frozen_out |=> fifo_level_out <= $past(fifo_level_out))
    else $error("frozen FIFO still capturing");
  a_rearm_clear: assert property (clr_write and cfg1[4] |=> detector_armed_out && !detect_wake_event_flag_out)
    else $error("clear did not rearm detector");
  a_no_rearm: assert property (clr_write and !cfg1[4] && !detector_armed_out && detect_and_wake_mode_out
    |=> !detector_armed_out)
    else $error("detector rearmed without rearm bit");
  a_short_wrap: assert property (burst_advance_in && !burst_end_out && burst_addr_out == 8'h07 && !cfg2[0]
    |=> burst_addr_out == 8'h02)
    else $error("short wrap address wrong");
  a_long_wrap: assert property (burst_advance_in && !burst_end_out && burst_addr_out == 8'h09 && cfg2[0]
    |=> burst_addr_out == 8'h02)
    else $error("long wrap address wrong");
  a_six_bytes: assert property (short_start ##1 six_steps |=> burst_end_out)
    else $error("plain burst did not end after six bytes");
endmodule
bind sensor_feature_config_regs sensor_feature_config_regs_asserts checker_inst (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_write_in(reg_write_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_via_serial_in(reg_via_serial_in), .burst_start_in(burst_start_in),
  .burst_addr_in(burst_addr_in), .burst_advance_in(burst_advance_in), .burst_addr_out(burst_addr_out),
  .burst_end_out(burst_end_out), .serial_port_enable_out(serial_port_enable_out),
  .two_wire_port_enable_out(two_wire_port_enable_out), .detector_hit_in(detector_hit_in),
  .three_wire_serial_select_out(three_wire_serial_select_out), .detect_and_wake_mode_out(detect_and_wake_mode_out),
  .detect_wake_event_flag_out(detect_wake_event_flag_out), .detector_armed_out(detector_armed_out),
  .axis_output_enable_out(axis_output_enable_out), .fifo_frozen_out(fifo_frozen_out), .fifo_level_out(fifo_level_out));

// *** tb/stream_sink_model.sv ***
/*
  Consumer of the sample stream; takes a word every cycle or stalls.
  Assumes the bench clock and active-low reset.
*/
`timescale 1ns/10ps
module stream_sink_model (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Stall control and handshake
  input wire logic slow_in,
  output logic sample_ready_out
);
  logic [1:0] phase; // Stall pattern counter
  // Free running phase for the slow pattern
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  // Ready one cycle in four when slow
  assign sample_ready_out = !slow_in || phase == 2'h3;
endmodule

// *** tb/sensor_feature_config_regs_test.sv ***
/*
  Self-checking bench for the feature register bank.
  Assumes the checker bind and the stream sink model.
*/
`timescale 1ns/10ps
module sensor_feature_config_regs_test;
  logic core_clk_in, rst_n_in, reg_write_in, reg_read_in, reg_via_serial_in, burst_start_in, burst_advance_in;
  logic burst_end_out, detector_hit_in, sample_valid_in, fifo_enable_in, slow, sample_valid_out, sample_ready_in;
  logic serial_port_enable_out, two_wire_port_enable_out, three_wire_serial_select_out, detect_and_wake_mode_out;
  logic detect_wake_event_flag_out, detector_armed_out, axis_output_enable_out, fifo_frozen_out, rd_pend, adv_pend;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, burst_addr_in, burst_addr_out;
  logic [2:0] op_mode_in;
  logic [47:0] sample_data_in, sample_data_out;
  logic [5:0] fifo_level_out;
  logic [31:0] lfsr = 32'h655C;
  logic [31:0] v;
  logic [7:0] rd_q[$], ad_q[$];
  logic [47:0] sd_q[$];
  int num_errors = 0;
  int n_compared = 0;
  logic skip = 1'b0;
  logic [47:0] last_in, last_seen;
  // Clock
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  sensor_feature_config_regs DUT (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_via_serial_in(reg_via_serial_in), .burst_start_in(burst_start_in), .burst_addr_in(burst_addr_in),
    .burst_advance_in(burst_advance_in), .burst_addr_out(burst_addr_out), .burst_end_out(burst_end_out),
    .serial_port_enable_out(serial_port_enable_out), .two_wire_port_enable_out(two_wire_port_enable_out),
    .three_wire_serial_select_out(three_wire_serial_select_out), .op_mode_in(op_mode_in),
    .detector_hit_in(detector_hit_in), .sample_valid_in(sample_valid_in), .sample_data_in(sample_data_in),
    .fifo_enable_in(fifo_enable_in), .detect_and_wake_mode_out(detect_and_wake_mode_out),
    .detect_wake_event_flag_out(detect_wake_event_flag_out), .detector_armed_out(detector_armed_out),
    .axis_output_enable_out(axis_output_enable_out), .fifo_frozen_out(fifo_frozen_out),
    .sample_valid_out(sample_valid_out), .sample_data_out(sample_data_out), .sample_ready_in(sample_ready_in),
    .fifo_level_out(fifo_level_out));
  stream_sink_model sink (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .slow_in(slow),
    .sample_ready_out(sample_ready_in));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic chk(string what, logic [47:0] exp, logic [47:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] got);
    chk(what, {40'h0, exp}, {40'h0, got});
  endtask
  task automatic step();
    @(posedge core_clk_in);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_write_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    step();
    reg_write_in = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    rd_q.push_back(e);
    reg_read_in = 1'b1;
    reg_addr_in = a;
    step();
    reg_read_in = 1'b0;
  endtask
  task automatic push(bit keep);
    logic [63:0] t;
    t = {rnd(), rnd()};
    sample_data_in = t[47:0];
    last_in = t[47:0];
    if (keep) sd_q.push_back(t[47:0]);
    sample_valid_in = 1'b1;
    step();
  endtask
  // Burst from 0x02 with n advances, checking every address
  task automatic burst(logic [7:0] cfg, int n);
    logic [7:0] a;
    wr(8'h0E, cfg);
    a = 8'h02;
    burst_addr_in = a;
    burst_start_in = 1'b1;
    step();
    burst_start_in = 1'b0;
    for (int i = 0; i < n; i++) begin
      a = (a == (cfg[0] ? 8'h09 : 8'h07)) ? 8'h02 : a + 8'h01;
      ad_q.push_back(a);
      burst_advance_in = 1'b1;
      if (i == n - 1) chk("burst_end_early", 48'h0, {47'h0, burst_end_out});
      step();
    end
    burst_advance_in = 1'b0;
    chk("burst_end", 48'h1, {47'h0, burst_end_out});
  endtask
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Monitor: results against the oldest notes
  always @(posedge core_clk_in) begin
    if (rd_pend) chk_byte("reg_rdata", rd_q.pop_front(), reg_rdata_out);
    if (adv_pend) chk_byte("burst_addr", ad_q.pop_front(), burst_addr_out);
    if (sample_valid_out === 1'b1 && sample_ready_in === 1'b1 && skip) last_seen = sample_data_out;
    if (sample_valid_out === 1'b1 && sample_ready_in === 1'b1 && !skip) chk("sample", sd_q.pop_front(), sample_data_out);
    rd_pend = reg_read_in;
    adv_pend = burst_advance_in;
  end
  // Watchdog
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_n_in, reg_write_in, reg_read_in, reg_via_serial_in, burst_start_in, burst_advance_in} = 6'h00;
    {detector_hit_in, sample_valid_in, fifo_enable_in, slow, rd_pend, adv_pend} = 6'h00;
    {reg_addr_in, reg_wdata_in, burst_addr_in, op_mode_in, sample_data_in} = 75'h0;
    repeat (20) @(posedge core_clk_in);
    #1 rst_n_in = 1'b1;
    rd(8'h0D, 8'h00);
    rd(8'h0E, 8'h00);
    rd(8'h55, 8'h00);
    repeat (4) begin
      v = rnd();
      wr(8'h0D, {v[7], !v[7], v[5:0]});
      rd(8'h0D, {v[7], !v[7], v[5:3], 3'h0});
      wr(8'h0E, v[15:8]);
      rd(8'h0E, v[15:8]);
    end
    wr(8'h0D, 8'h60);
    chk("serial_enable", 48'h0, {47'h0, serial_port_enable_out});
    chk("three_wire", 48'h1, {47'h0, three_wire_serial_select_out});
    wr(8'h0D, 8'h80);
    chk("two_wire_enable", 48'h0, {47'h0, two_wire_port_enable_out});
    burst(8'h00, 6);
    burst(8'h01, 8);
    burst(8'h02, 192);
    burst(8'h03, 256);
    wr(8'h0E, 8'h00);
    wr(8'h0D, 8'h00);
    fifo_enable_in = 1'b1;
    push(0);
    sample_valid_in = 1'b0;
    repeat (3) step();
    chk("level_unselected", 48'h0, {42'h0, fifo_level_out});
    wr(8'h0D, 8'h80);
    slow = 1'b1;
    repeat (14) push(1);
    sample_valid_in = 1'b0;
    repeat (60) step();
    // Stream mode: overfill, then the newest word must drain last
    wr(8'h0E, 8'h20);
    skip = 1'b1;
    repeat (60) push(0);
    sample_valid_in = 1'b0;
    chk("level_full", 48'h20, {42'h0, fifo_level_out});
    slow = 1'b0;
    repeat (45) step();
    chk("newest_kept", last_in, last_seen);
    skip = 1'b0;
    wr(8'h0D, 8'h98);
    op_mode_in = 3'h6;
    reg_via_serial_in = 1'b1;
    detector_hit_in = 1'b1;
    step();
    detector_hit_in = 1'b0;
    chk("mode", 48'h1, {47'h0, detect_and_wake_mode_out});
    chk("frozen", 48'h1, {47'h0, fifo_frozen_out});
    push(0);
    sample_valid_in = 1'b0;
    rd(8'h09, 8'h80);
    rd(8'h09, 8'h80);
    wr(8'h09, 8'h00);
    chk("armed_after_clear", 48'h1, {47'h0, detector_armed_out});
    wr(8'h0D, 8'h40);
    detector_hit_in = 1'b1;
    step();
    detector_hit_in = 1'b0;
    push(1);
    sample_valid_in = 1'b0;
    reg_via_serial_in = 1'b0;
    rd(8'h09, 8'h80);
    rd(8'h09, 8'h00);
    reg_via_serial_in = 1'b1;
    wr(8'h09, 8'h00);
    chk("armed_no_rearm", 48'h0, {47'h0, detector_armed_out});
    op_mode_in = 3'h0;
    step();
    chk("armed_mode_exit", 48'h1, {47'h0, detector_armed_out});
    detector_hit_in = 1'b1;
    step();
    detector_hit_in = 1'b0;
    chk("flag_out_of_mode", 48'h0, {47'h0, detect_wake_event_flag_out});
    // Two-wire write-clear method
    wr(8'h0E, 8'h10);
    reg_via_serial_in = 1'b0;
    op_mode_in = 3'h6;
    detector_hit_in = 1'b1;
    step();
    detector_hit_in = 1'b0;
    rd(8'h09, 8'h80);
    rd(8'h09, 8'h80);
    wr(8'h09, 8'h00);
    rd(8'h09, 8'h00);
    repeat (10) step();
    conclude();
  end
endmodule
